/* drive_serial_register_map.sv */
// register map of the drive as seen by the serial bus master
// assumes the framer checks station address and crc, and splits multi-item
// frames into one access per item, one per cycle at most
//
// Contract
// (RQ1) coils only via 01h, 05h, 0fh
// (RQ2) coils 0-7 read-only drive status bits
// (RQ3) command coils fire on ff00, run on 0100
// (RQ4) fourteen read-only input words via 04h
// (RQ5) switch word bits 0-5 are terminals
// (RQ6) fault word is class base plus variant
// (RQ7) holding space only via 03h, 06h, 10h
// (RQ8) holding 0000-00ff are the 256 parameters
// (RQ9) command word bits act as command coils
// (RQ10) frequency reference used when source is 2
// (RQ11) virtual inputs low, bits 0-7 ignored
// (RQ12) virtual inputs high drive functions 17-32
// (RQ13) digital output word bit 3 drives relay
// (RQ14) analog output word drives output pin
// (RQ15) state word mirrors coils 0-15
// (RQ16) terminal word: inputs bits 0-5, relay 11
// (RQ17) virtual output words, one function per bit
// (RQ18) holding 0220-022d mirror input words
// (RQ19) analog inputs and pulse input readable
// (RQ20) only parameter writes go to nonvolatile store
// (RQ21) undefined address answers exception 02
// (RQ22) reserved reads zero, writes change nothing

`timescale 1ns/1ps
`include "drive_regmap_map.svh"

module drive_serial_register_map #(
   parameter int NUM_PARAMS = 256    // configuration parameter count
) (
   input  wire logic                         CLK,
   input  wire logic                         RSTN,
   input  wire logic                         REQ_VALID,
   input  wire drive_regmap_pkg::modbus_req_t REQ,
   output logic                              RSP_VALID,
   output drive_regmap_pkg::modbus_rsp_t     RSP,
   input  wire logic [7:0]                   STATUS_COILS,
   input  wire logic [13:0][15:0]            MEASURE,
   input  wire drive_regmap_pkg::fault_t     FAULT,
   input  wire logic [5:0]                   SWITCH_INPUT_TERMINALS,
   input  wire logic                         RELAY_STATE,
   input  wire logic [31:0]                  VIRT_OUTPUTS,
   input  wire logic [15:0]                  ANALOG_INPUT_ONE,
   input  wire logic [15:0]                  ANALOG_INPUT_TWO,
   input  wire logic [15:0]                  PULSE_FREQUENCY_INPUT,
   output logic [7:0]                        CMD_PULSE,
   output logic [31:0]                       VIRT_INPUTS,
   output logic [15:0]                       FREQ_REF,
   output logic                              FREQ_REF_VALID,
   output logic [15:0]                       REMOTE_DIGITAL_OUTPUT_WORD,
   output logic                              RELAY_DRIVE,
   output logic [15:0]                       REMOTE_ANALOG_OUTPUT_WORD,
   output logic [15:0]                       FREQUENCY_SOURCE_SELECT,
   output logic                              NV_WRITE,
   output logic [7:0]                        NV_ADDR,
   output logic [15:0]                       NV_DATA
);

   // parameter store, power-up values come from the nonvolatile side later
   logic [15:0] param_mem [NUM_PARAMS];

   logic [15:0] cmd_word_reg;     // last written command word
   logic [15:0] freq_ref_reg;     // frequency reference
   logic [15:0] vin_low_reg;      // virtual inputs 1-16
   logic [15:0] vin_high_reg;     // virtual inputs 17-32
   logic [15:0] do_word_reg;      // remote digital outputs
   logic [15:0] ao_word_reg;      // remote analog output
   logic [15:0] freq_src_reg;     // copy of the source selection parameter

   // decode results
   logic [7:0]  exc_next;         // exception for this access
   logic [15:0] rdata_next;       // read value for this access
   logic        coil_fire;        // command coil write that activates
   logic        param_wr;         // parameter write accepted
   logic        vol_wr;           // volatile holding write accepted
   logic [7:0]  cmd_pulse_next;   // command pulses from this access

   // inside a closed range
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // fault class to decimal code
   function automatic logic [15:0] fault_code(
      input drive_regmap_pkg::fault_t f);
      logic [7:0] base;
      base = 8'h00;

      unique case (f.fclass)
         drive_regmap_pkg::FAULT_NONE:      base = 8'h00;
         drive_regmap_pkg::OVERCURRENT:     base = `FAULT_BASE_OC;
         drive_regmap_pkg::OVERVOLTAGE:     base = `FAULT_BASE_OV;
         drive_regmap_pkg::UNDERVOLTAGE:    base = `FAULT_BASE_UV;
         drive_regmap_pkg::OVERHEAT:        base = `FAULT_BASE_OH;
         drive_regmap_pkg::OVERLOAD:        base = `FAULT_BASE_OL;
         drive_regmap_pkg::FAULT_CLASS_100: base = `FAULT_BASE_C100;
         drive_regmap_pkg::FAULT_CLASS_104: base = `FAULT_BASE_C104;
      endcase

      // no fault reads plain zero, variant ignored
      if (f.fclass == drive_regmap_pkg::FAULT_NONE) begin
         fault_code = 16'h0000;
      end else begin
         fault_code = {8'h00, base + {6'h00, f.variant}};
      end
   endfunction

   // one input register word, shared by input space and holding mirror
   function automatic logic [15:0] inreg_word(input logic [3:0] idx);
      inreg_word = 16'h0000;

      if (idx == `INREG_FAULT_IDX) begin
         // (RQ6) fault class code
         inreg_word = fault_code(FAULT);
      end else if (idx == `INREG_SWITCH_IDX) begin
         // (RQ5) closed terminal reads one
         inreg_word = {10'h000, SWITCH_INPUT_TERMINALS};
      end else if (idx <= `INREG_SWITCH_IDX) begin
         inreg_word = MEASURE[idx];
      end
   endfunction

   // access decode, read mux and write qualification
   always_comb begin
      exc_next       = `EXC_NONE;
      rdata_next     = 16'h0000;
      coil_fire      = 1'b0;
      param_wr       = 1'b0;
      vol_wr         = 1'b0;
      cmd_pulse_next = 8'h00;

      case (REQ.func)
         // (RQ1) coil functions reach coil space
         `FC_READ_COILS, `FC_WRITE_COIL, `FC_WRITE_COILS: begin
            if (REQ.addr <= `COIL_RESV_LAST) begin
               if (REQ.func != `FC_READ_COILS) begin
                  // status coils refuse writes, reserved ones ignore them
                  if (REQ.addr <= `COIL_STATUS_LAST) begin
                     exc_next = `EXC_FAIL;
                  end
               end else if (REQ.addr <= `COIL_STATUS_LAST) begin
                  // (RQ2) drive status bit
                  rdata_next = {15'h0000, STATUS_COILS[REQ.addr[2:0]]};
               end
            end else if (in_range(REQ.addr, `COIL_CMD_FIRST, `COIL_CMD_LAST)) begin
               // command coils are write-only and read zero
               if (REQ.func != `FC_READ_COILS) begin
                  // (RQ3) ff00 fires, 0000 is no-op, run also takes 0100
                  if (REQ.wdata == `COIL_ON) begin
                     coil_fire = 1'b1;
                  end else if (REQ.wdata == `COIL_RUN_ALT && REQ.addr[2:0] == 3'h0) begin
                     coil_fire = 1'b1;
                  end else if (REQ.wdata != `COIL_OFF) begin
                     exc_next = `EXC_VALUE;
                  end
                  if (coil_fire) begin
                     cmd_pulse_next = 8'h01 << REQ.addr[2:0];
                  end
               end
            end else begin
               // (RQ21) beyond the coil map
               exc_next = `EXC_ADDR;
            end
         end

         // (RQ4) input words, read only
         `FC_READ_INPUT: begin
            if (REQ.addr <= `INREG_LAST) begin
               rdata_next = inreg_word(REQ.addr[3:0]);
            end else begin
               exc_next = `EXC_ADDR;
            end
         end

         // (RQ7) holding functions reach holding space
         `FC_READ_HOLDING, `FC_WRITE_HOLDING, `FC_WRITE_HOLDINGS: begin
            if (REQ.addr <= `PARAM_LAST) begin
               // (RQ8) parameter window
               rdata_next = param_mem[REQ.addr[7:0]];
               param_wr   = (REQ.func != `FC_READ_HOLDING);
            end else if (in_range(REQ.addr, `HR_CMD, `HR_AO)) begin
               vol_wr = (REQ.func != `FC_READ_HOLDING);
               unique case (REQ.addr[2:0])
                  3'h0: rdata_next = cmd_word_reg;
                  3'h1: rdata_next = freq_ref_reg;
                  3'h2: rdata_next = vin_low_reg;
                  3'h3: rdata_next = vin_high_reg;
                  3'h4: rdata_next = do_word_reg;
                  3'h5: rdata_next = ao_word_reg;
                  default: rdata_next = 16'h0000;
               endcase

               // (RQ9) command word bits fire like coils
               if (vol_wr && REQ.addr == `HR_CMD) begin
                  cmd_pulse_next = REQ.wdata[7:0];
               end
            end else if (in_range(REQ.addr, `HR_STATE, `HR_VOUT_HIGH)
                         || in_range(REQ.addr, `HR_MIRROR_FIRST, `HR_PULSE)) begin
               // status words refuse writes
               if (REQ.func != `FC_READ_HOLDING) begin
                  exc_next = `EXC_FAIL;
               end
               if (REQ.addr == `HR_STATE) begin
                  // (RQ15) coils 0-15, reserved coils read zero
                  rdata_next = {8'h00, STATUS_COILS};
               end else if (REQ.addr == `HR_TERMINALS) begin
                  // (RQ16) inputs and relay state
                  rdata_next = {10'h000, SWITCH_INPUT_TERMINALS};
                  rdata_next[`TERM_RELAY_BIT] = RELAY_STATE;
               end else if (REQ.addr == `HR_VOUT_LOW) begin
                  // (RQ17) virtual outputs 1-16
                  rdata_next = VIRT_OUTPUTS[15:0];
               end else if (REQ.addr == `HR_VOUT_HIGH) begin
                  // (RQ17) virtual outputs 17-32
                  rdata_next = VIRT_OUTPUTS[31:16];
               end else if (REQ.addr <= `HR_MIRROR_LAST) begin
                  // (RQ18) same words as the input space
                  rdata_next = inreg_word(4'(REQ.addr - `HR_MIRROR_FIRST));
               end else if (REQ.addr == `HR_AI1) begin
                  // (RQ19) analog and pulse inputs
                  rdata_next = ANALOG_INPUT_ONE;
               end else if (REQ.addr == `HR_AI2) begin
                  rdata_next = ANALOG_INPUT_TWO;
               end else begin
                  rdata_next = PULSE_FREQUENCY_INPUT;
               end
            end else if (in_range(REQ.addr, `HR_VOLATILE_FIRST, `HR_LAST)) begin
               // (RQ22) reserved gaps read zero, writes dropped
               rdata_next = 16'h0000;
            end else begin
               // (RQ21) outside the holding map
               exc_next = `EXC_ADDR;
            end
         end

         default: begin
            exc_next = `EXC_FUNC;
         end
      endcase
   end

   // answer registers, one cycle after the request
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RSP_VALID <= 1'b0;
         RSP       <= '0;
      end else begin
         RSP_VALID <= REQ_VALID;
         if (REQ_VALID) begin
            RSP.exc   <= exc_next;
            RSP.rdata <= rdata_next;
         end
      end
   end

   // command pulses last exactly one cycle
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         CMD_PULSE <= 8'h00;
      end else begin
         CMD_PULSE <= REQ_VALID ? cmd_pulse_next : 8'h00;
      end
   end

   // parameter store, no reset so it maps onto plain ram
   always_ff @(posedge CLK) begin
      if (REQ_VALID && param_wr) begin
         param_mem[REQ.addr[7:0]] <= REQ.wdata;
      end
   end

   // nonvolatile commit request and source-selection copy
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         NV_WRITE     <= 1'b0;
         NV_ADDR      <= 8'h00;
         NV_DATA      <= `REG_RESET;
         freq_src_reg <= `REG_RESET;
      end else begin
         // (RQ20) only parameter writes reach nonvolatile storage
         NV_WRITE <= REQ_VALID && param_wr;
         if (REQ_VALID && param_wr) begin
            NV_ADDR <= REQ.addr[7:0];
            NV_DATA <= REQ.wdata;

            // copy kept in flops so the source output needs no ram read port
            if (REQ.addr[7:0] == `PARAM_FREQ_SRC) begin
               freq_src_reg <= REQ.wdata;
            end
         end
      end
   end

   // volatile communication words, lost on power loss by design
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmd_word_reg <= `REG_RESET;
         freq_ref_reg <= `REG_RESET;
         vin_low_reg  <= `REG_RESET;
         vin_high_reg <= `REG_RESET;
         do_word_reg  <= `REG_RESET;
         ao_word_reg  <= `REG_RESET;
      end else if (REQ_VALID && vol_wr) begin
         unique case (REQ.addr[2:0])
            3'h0: cmd_word_reg <= REQ.wdata & `CMD_WORD_MASK;
            3'h1: freq_ref_reg <= REQ.wdata;

            // (RQ11) functions 1-8 belong to the command word
            3'h2: vin_low_reg  <= REQ.wdata & `VIN_LOW_KEEP;
            // (RQ12) functions 17-32
            3'h3: vin_high_reg <= REQ.wdata;
            3'h4: do_word_reg  <= REQ.wdata;
            3'h5: ao_word_reg  <= REQ.wdata;
            default: cmd_word_reg <= cmd_word_reg;
         endcase
      end
   end

   // virtual inputs act only while the command word enables them
   assign VIRT_INPUTS = cmd_word_reg[`CMD_VIN_EN_BIT] ?
      {vin_high_reg, vin_low_reg} : 32'h0;

   // (RQ10) reference counts only with the comm port selected
   assign FREQ_REF_VALID = (freq_src_reg == `FREQ_SRC_COMM);
   assign FREQ_REF       = freq_ref_reg;
   assign FREQUENCY_SOURCE_SELECT = freq_src_reg;

   // (RQ13) relay follows bit 3 of the output word
   assign RELAY_DRIVE                = do_word_reg[`DO_RELAY_BIT];
   assign REMOTE_DIGITAL_OUTPUT_WORD = do_word_reg;

   // (RQ14) analog output value under comm control
   assign REMOTE_ANALOG_OUTPUT_WORD = ao_word_reg;

endmodule

/* drive_regmap_map.svh */
// offsets, field positions, reset values and codes of the drive serial register map
// assumes a framing block that splits every request into single-item accesses
`ifndef DRIVE_REGMAP_MAP_SVH
`define DRIVE_REGMAP_MAP_SVH

// function codes
`define FC_READ_COILS     8'h01
`define FC_READ_HOLDING   8'h03
`define FC_READ_INPUT     8'h04
`define FC_WRITE_COIL     8'h05
`define FC_WRITE_HOLDING  8'h06
`define FC_WRITE_COILS    8'h0f
`define FC_WRITE_HOLDINGS 8'h10

// exception codes, zero means a normal answer
`define EXC_NONE  8'h00
`define EXC_FUNC  8'h01
`define EXC_ADDR  8'h02
`define EXC_VALUE 8'h03
`define EXC_FAIL  8'h04

// coil space
`define COIL_STATUS_LAST 16'h0007
`define COIL_RESV_LAST   16'h0047
`define COIL_CMD_FIRST   16'h0048
`define COIL_CMD_LAST    16'h004f
`define COIL_ON          16'hff00
`define COIL_OFF         16'h0000
`define COIL_RUN_ALT     16'h0100

// input register space
`define INREG_LAST      16'h000d
`define INREG_FAULT_IDX 4'ha
`define INREG_SWITCH_IDX 4'hd

// holding register space
`define PARAM_LAST       16'h00ff
`define HR_VOLATILE_FIRST 16'h0200
`define HR_CMD           16'h0200
`define HR_FREQ_REF      16'h0201
`define HR_VIN_LOW       16'h0202
`define HR_VIN_HIGH      16'h0203
`define HR_DO            16'h0204
`define HR_AO            16'h0205
`define HR_RESV1_LAST    16'h020f
`define HR_STATE         16'h0210
`define HR_TERMINALS     16'h0211
`define HR_VOUT_LOW      16'h0212
`define HR_VOUT_HIGH     16'h0213
`define HR_RESV2_LAST    16'h021f
`define HR_MIRROR_FIRST  16'h0220
`define HR_MIRROR_LAST   16'h022d
`define HR_AI1           16'h022e
`define HR_AI2           16'h022f
`define HR_PULSE         16'h0230
`define HR_LAST          16'h023f

// field positions and values
`define CMD_VIN_EN_BIT   8
`define CMD_WORD_MASK    16'h01ff
`define VIN_LOW_KEEP     16'hff00
`define DO_RELAY_BIT     3
`define TERM_RELAY_BIT   11
`define PARAM_FREQ_SRC   8'h02
`define FREQ_SRC_COMM    16'h0002
`define REG_RESET        16'h0000

// fault class bases
`define FAULT_BASE_OC 8'h40
`define FAULT_BASE_OV 8'h50
`define FAULT_BASE_UV 8'h58
`define FAULT_BASE_OH 8'h5c
`define FAULT_BASE_OL 8'h60
`define FAULT_BASE_C100 8'h64
`define FAULT_BASE_C104 8'h68

`endif

/* drive_regmap_pkg.sv */
// types shared by the drive serial register map and its framing block
// assumes the framing block fills a request struct per single item
package drive_regmap_pkg;

   // one single-item access from the framer
   typedef struct packed {
      logic [7:0]  func;   // function code of the frame
      logic [15:0] addr;   // item address
      logic [15:0] wdata;  // write value, coil state for coil writes
   } modbus_req_t;

   // answer to one access
   typedef struct packed {
      logic [7:0]  exc;    // exception code, zero when normal
      logic [15:0] rdata;  // read value, coil in bit 0
   } modbus_rsp_t;

   // active fault class
   typedef enum logic [2:0] {
      FAULT_NONE       = 3'h0,
      OVERCURRENT      = 3'h1,
      OVERVOLTAGE      = 3'h2,
      UNDERVOLTAGE     = 3'h3,
      OVERHEAT         = 3'h4,
      OVERLOAD         = 3'h5,
      FAULT_CLASS_100  = 3'h6,
      FAULT_CLASS_104  = 3'h7
   } fault_class_t;

   // fault report from the drive core
   typedef struct packed {
      fault_class_t fclass;   // which class is active
      logic [1:0]   variant;  // suffix variant, 0 to 3
   } fault_t;

endpackage

/* drive_regmap_checker.sv */
// assertions on the ports of the drive serial register map
// assumes binding to the top module, one clock, async low reset
`timescale 1ns/1ps
`include "drive_regmap_map.svh"

module drive_regmap_checker #(
   parameter int NUM_PARAMS = 256  // parameter count, kept in step with the map
) (
   input wire logic                          CLK,
   input wire logic                          RSTN,
   input wire logic                          REQ_VALID,
   input wire drive_regmap_pkg::modbus_req_t REQ,
   input wire logic                          RSP_VALID,
   input wire drive_regmap_pkg::modbus_rsp_t RSP,
   input wire logic [7:0]                    STATUS_COILS,
   input wire logic [5:0]                    SWITCH_INPUT_TERMINALS,
   input wire logic [7:0]                    CMD_PULSE,
   input wire logic [31:0]                   VIRT_INPUTS,
   input wire logic [15:0]                   REMOTE_DIGITAL_OUTPUT_WORD,
   input wire logic                          RELAY_DRIVE,
   input wire logic                          NV_WRITE
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   AST_RSP_NEXT: assert property (REQ_VALID |=> RSP_VALID)
      else $error("access not answered next cycle");
   AST_RSP_ONLY: assert property (!REQ_VALID |=> !RSP_VALID)
      else $error("answer without access");
   AST_BAD_FUNC: assert property (REQ_VALID && !(REQ.func inside {8'h01, 8'h03, 8'h04,
      8'h05, 8'h06, 8'h0f, 8'h10}) |=> RSP.exc == `EXC_FUNC)
      else $error("unknown function not refused");
   AST_COIL_RANGE: assert property (REQ_VALID && REQ.func == 8'h01 &&
      REQ.addr > `COIL_CMD_LAST |=> RSP.exc == `EXC_ADDR)
      else $error("coil beyond map not refused");
   AST_CMD_COIL: assert property (REQ_VALID && REQ.func == 8'h05 && REQ.wdata == 16'hff00 &&
      REQ.addr inside {[16'h0048:16'h004f]} |=> CMD_PULSE == (8'h01 << $past(REQ.addr[2:0])))
      else $error("command coil pulse wrong");
   AST_CMD_QUIET: assert property (!REQ_VALID |=> CMD_PULSE == 8'h00)
      else $error("command pulse without access");
   AST_STATUS: assert property (REQ_VALID && REQ.func == 8'h01 &&
      REQ.addr <= `COIL_STATUS_LAST |=> RSP.rdata == {15'h0, $past(STATUS_COILS[REQ.addr[2:0]])})
      else $error("status coil read wrong");
   AST_SWITCH: assert property (REQ_VALID && REQ.func == 8'h04 &&
      REQ.addr == `INREG_LAST |=> RSP.rdata == {10'h0, $past(SWITCH_INPUT_TERMINALS)})
      else $error("switch word wrong");
   AST_NV_PARAM: assert property (NV_WRITE |-> $past(REQ_VALID &&
      REQ.addr <= `PARAM_LAST && REQ.func inside {8'h06, 8'h10}))
      else $error("nonvolatile write without parameter write");
   AST_RELAY: assert property (RELAY_DRIVE == REMOTE_DIGITAL_OUTPUT_WORD[3])
      else $error("relay drive not bit 3");
   AST_VIN_LOW: assert property (VIRT_INPUTS[7:0] == 8'h00)
      else $error("virtual inputs 1 to 8 not ignored");
endmodule

bind drive_serial_register_map drive_regmap_checker #(.NUM_PARAMS(NUM_PARAMS)) chk_u (
   .CLK(CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID), .REQ(REQ), .RSP_VALID(RSP_VALID),
   .RSP(RSP), .STATUS_COILS(STATUS_COILS), .SWITCH_INPUT_TERMINALS(SWITCH_INPUT_TERMINALS),
   .CMD_PULSE(CMD_PULSE), .VIRT_INPUTS(VIRT_INPUTS),
   .REMOTE_DIGITAL_OUTPUT_WORD(REMOTE_DIGITAL_OUTPUT_WORD), .RELAY_DRIVE(RELAY_DRIVE),
   .NV_WRITE(NV_WRITE));

/* bus_master_model.sv */
// framer-side master, one single-item access at a time
// assumes the map registers its answer on the taking edge, read back at the next falling edge
`timescale 1ns/1ps

module bus_master_model (
   input  wire logic                          CLK,
   output logic                               REQ_VALID,
   output drive_regmap_pkg::modbus_req_t      REQ,
   input  wire logic                          RSP_VALID,
   input  wire drive_regmap_pkg::modbus_rsp_t RSP
);
   // idle at time zero
   initial begin
      REQ_VALID = 1'b0;
      REQ = '0;
   end

   // one access, held from a falling edge past the taking edge
   task automatic access(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                         output drive_regmap_pkg::modbus_rsp_t r, output logic ok);
      @(negedge CLK);
      // codes and values from the caller
      REQ_VALID = 1'b1;
      REQ = '{func: f, addr: a, wdata: d};
      @(posedge CLK);
      @(negedge CLK);
      // released lines show the inverse, not stale data
      REQ_VALID = 1'b0;
      REQ = ~REQ;
      ok = (RSP_VALID === 1'b1);
      r = RSP;
   endtask
endmodule

/* testbench.sv */
// self-checking bench for the drive serial register map
// assumes the master model drives all accesses, inputs move at falling edges
`timescale 1ns/1ps

module testbench;
   logic                          CLK;            // 50 ns clock
   logic                          RSTN;           // async low reset
   logic                          req_valid;      // from master model
   drive_regmap_pkg::modbus_req_t req;            // access from master model
   logic                          rsp_valid;      // answer strobe
   drive_regmap_pkg::modbus_rsp_t rsp;            // answer
   logic [7:0]                    status;         // drive status bits
   logic [13:0][15:0]             measure;        // input words
   drive_regmap_pkg::fault_t      fault;          // active fault
   logic [5:0]                    sw;             // switch terminals
   logic                          relay;          // relay state
   logic [31:0]                   vout;           // virtual outputs
   logic [15:0]                   ai1, ai2, pls;  // analog and pulse inputs
   logic [7:0]                    cmd;
   logic [31:0]                   vin;
   logic [15:0]                   fref, rdo, rao, fsel, nvd;
   logic                          fref_ok, rly, nvw;
   logic [7:0]                    nva;
   int                            err_count;
   int                            total_checks;
   int                            i;
   logic [15:0]                   e;

   drive_serial_register_map #(.NUM_PARAMS(256)) dut_u (
      .CLK(CLK), .RSTN(RSTN), .REQ_VALID(req_valid), .REQ(req), .RSP_VALID(rsp_valid),
      .RSP(rsp), .STATUS_COILS(status), .MEASURE(measure), .FAULT(fault),
      .SWITCH_INPUT_TERMINALS(sw), .RELAY_STATE(relay), .VIRT_OUTPUTS(vout),
      .ANALOG_INPUT_ONE(ai1), .ANALOG_INPUT_TWO(ai2), .PULSE_FREQUENCY_INPUT(pls),
      .CMD_PULSE(cmd), .VIRT_INPUTS(vin), .FREQ_REF(fref), .FREQ_REF_VALID(fref_ok),
      .REMOTE_DIGITAL_OUTPUT_WORD(rdo), .RELAY_DRIVE(rly), .REMOTE_ANALOG_OUTPUT_WORD(rao),
      .FREQUENCY_SOURCE_SELECT(fsel), .NV_WRITE(nvw), .NV_ADDR(nva), .NV_DATA(nvd));

   bus_master_model mst_u (
      .CLK(CLK), .REQ_VALID(req_valid), .REQ(req), .RSP_VALID(rsp_valid), .RSP(rsp));

   // free-running clock
   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   // single place that ends the run
   task automatic results();
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one access; rdata checked on reads only, writes return old data
   task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                       input logic [7:0] ex, input logic [15:0] x, input bit rd);
      drive_regmap_pkg::modbus_rsp_t r;
      logic ok;
      mst_u.access(f, a, d, r, ok);
      if (ok !== 1'b1) begin
         err_count++;
         $display("Error at %0t: no answer", $time);
         results();
      end else begin
         chk({8'h00, r.exc}, {8'h00, ex});
         if (rd) chk(r.rdata, x);
      end
   endtask

   initial begin
      err_count = 0;
      total_checks = 0;
      RSTN = 1'b0;
      status = 8'ha5;
      for (i = 0; i < 14; i++) measure[i] = 16'h1000 + 16'(i);
      fault = '{fclass: drive_regmap_pkg::OVERHEAT, variant: 2'h3};
      sw = 6'h2d;
      relay = 1'b1;
      vout = 32'hcafe_0123;
      ai1 = 16'h2710;
      ai2 = 16'h1388;
      pls = 16'h0abc;
      repeat (3) @(negedge CLK);
      RSTN = 1'b1;
      chk({15'h0, fref_ok}, 16'h0000);
      for (i = 0; i < 8; i++) xfer(8'h01, 16'(i), 16'h0, 8'h00, {15'h0, status[i]}, 1);
      xfer(8'h05, 16'h0003, 16'hff00, 8'h04, 16'h0, 0);
      xfer(8'h01, 16'h0008, 16'h0, 8'h00, 16'h0000, 1);
      xfer(8'h01, 16'h0050, 16'h0, 8'h02, 16'h0, 0);
      xfer(8'h03, 16'h0210, 16'h0, 8'h00, 16'h00a5, 1);
      for (i = 0; i < 8; i++) begin
         xfer(8'h05, 16'h0048 + 16'(i), 16'hff00, 8'h00, 16'h0, 0);
         chk({8'h00, cmd}, 16'h0001 << i);
      end
      xfer(8'h05, 16'h0049, 16'h0000, 8'h00, 16'h0, 0);
      chk({8'h00, cmd}, 16'h0000);
      xfer(8'h05, 16'h0048, 16'h0100, 8'h00, 16'h0, 0);
      chk({8'h00, cmd}, 16'h0001);
      xfer(8'h05, 16'h0049, 16'h0100, 8'h03, 16'h0, 0);
      xfer(8'h0f, 16'h004b, 16'hff00, 8'h00, 16'h0, 0);
      chk({8'h00, cmd}, 16'h0008);
      for (i = 0; i < 14; i++) begin
         e = (i == 10) ? 16'h005f : (i == 13) ? 16'h002d : 16'h1000 + 16'(i);
         xfer(8'h04, 16'(i), 16'h0, 8'h00, e, 1);
         xfer(8'h03, 16'h0220 + 16'(i), 16'h0, 8'h00, e, 1);
      end
      xfer(8'h04, 16'h000e, 16'h0, 8'h02, 16'h0, 0);
      xfer(8'h06, 16'h0002, 16'h0002, 8'h00, 16'h0, 0);
      chk({7'h00, nvw, nva}, 16'h0102);
      chk(nvd, 16'h0002);
      chk({fsel[14:0], fref_ok}, 16'h0005);
      xfer(8'h03, 16'h0002, 16'h0, 8'h00, 16'h0002, 1);
      xfer(8'h10, 16'h0201, 16'h0bb8, 8'h00, 16'h0, 0);
      chk({15'h0, nvw}, 16'h0000);
      chk(fref, 16'h0bb8);
      xfer(8'h10, 16'h0200, 16'h0101, 8'h00, 16'h0, 0);
      chk({8'h00, cmd}, 16'h0001);
      xfer(8'h06, 16'h0202, 16'hffff, 8'h00, 16'h0, 0);
      xfer(8'h06, 16'h0203, 16'h1234, 8'h00, 16'h0, 0);
      chk(vin[15:0], 16'hff00);
      chk(vin[31:16], 16'h1234);
      xfer(8'h06, 16'h0200, 16'h0000, 8'h00, 16'h0, 0);
      chk(vin[31:16], 16'h0000);
      xfer(8'h06, 16'h0204, 16'h0008, 8'h00, 16'h0, 0);
      chk({rdo[14:0], rly}, 16'h0011);
      xfer(8'h06, 16'h0205, 16'h0abc, 8'h00, 16'h0, 0);
      chk(rao, 16'h0abc);
      xfer(8'h03, 16'h0211, 16'h0, 8'h00, 16'h082d, 1);
      xfer(8'h03, 16'h0212, 16'h0, 8'h00, 16'h0123, 1);
      xfer(8'h03, 16'h0213, 16'h0, 8'h00, 16'hcafe, 1);
      xfer(8'h03, 16'h022e, 16'h0, 8'h00, 16'h2710, 1);
      xfer(8'h03, 16'h022f, 16'h0, 8'h00, 16'h1388, 1);
      xfer(8'h03, 16'h0230, 16'h0, 8'h00, 16'h0abc, 1);
      xfer(8'h06, 16'h0206, 16'h5555, 8'h00, 16'h0, 0);
      xfer(8'h03, 16'h0206, 16'h0, 8'h00, 16'h0000, 1);
      xfer(8'h03, 16'h0100, 16'h0, 8'h02, 16'h0, 0);
      xfer(8'h03, 16'h0240, 16'h0, 8'h02, 16'h0, 0);
      xfer(8'h06, 16'h0210, 16'h0001, 8'h04, 16'h0, 0);
      xfer(8'h07, 16'h0000, 16'h0, 8'h01, 16'h0, 0);
      xfer(8'h06, 16'h0002, 16'h0001, 8'h00, 16'h0, 0);
      chk({15'h0, fref_ok}, 16'h0000);
      results();
   end
endmodule
